// ==== src/ichmux_regs.vh ====
/*
  Constants of the two-wire channel multiplexer: sampled input layout,
  control byte fields, reset values and slave address.
  Assumes it is included once per compile unit by its bare name.
*/
`ifndef ICHMUX_REGS_VH
`define ICHMUX_REGS_VH

// layout of the synchronised input vector
`define ICHMUX_SY_W        17
`define ICHMUX_SY_SCL      0
`define ICHMUX_SY_SDA      1
`define ICHMUX_SY_DCLK_LO  2
`define ICHMUX_SY_DDAT_LO  6
`define ICHMUX_SY_IRQ_LO   10
`define ICHMUX_SY_STRAP_LO 14

// drive vector layout: downstream clocks, downstream data, up clock, up data
`define ICHMUX_OE_W        10
`define ICHMUX_OE_UCLK     8
`define ICHMUX_OE_UDAT     9

// control byte fields
`define ICHMUX_CTL_EN      2
`define ICHMUX_CTL_SEL_HI  1
`define ICHMUX_CTL_RST     3'h0
`define ICHMUX_BYTE_BITS   4'h8

// fixed upper part of the 7-bit slave address (arbitrary default)
`define ICHMUX_ADDR_HI     4'hE

// slave states
`define ICHMUX_ST_IDLE     3'h0
`define ICHMUX_ST_ADDR     3'h1
`define ICHMUX_ST_ACKA     3'h2
`define ICHMUX_ST_WR       3'h3
`define ICHMUX_ST_ACKW     3'h4
`define ICHMUX_ST_RD       3'h5
`define ICHMUX_ST_RACK     3'h6
`define ICHMUX_ST_RACK2    3'h7

`endif

// ==== src/ichmux_top.v ====
/*
  Control logic of a 1-of-4 two-wire bus multiplexer with interrupt
  combining. Assumes open-drain wires resolved outside from the enables,
  and all pin inputs asynchronous to i_clk (re-sampled by two flops).
*/
`default_nettype none
`include "ichmux_regs.vh"

// Notes on behaviour
// RQ1: upstream clock/data pair is passed both ways to at most one of four pairs.
// RQ2: never more than one channel connected; choice fixed by the control register.
// RQ3: channel selection comes from the control register loaded over the bus.
// RQ4: four active-low interrupt inputs, one per downstream channel.
// RQ5: interrupt output is the AND of the four active-low inputs.
// RQ6: interrupt output is active low.
// RQ7: power-on reset clears registers, slave state; no channel connected.
// RQ8: three strap inputs form the low address bits; master uses that address.
// RQ9: control port is a standard two-wire slave, also fine with SMBus masters.
// RQ10: works from static clock up to 400 kHz; master model runs 160 ns bits, far above it.
// RQ11: selection changes only by bus commands; no select pins.
// RQ12: bit 2 clear means none; set, bits 1:0 pick channel 0 to 3.
// RQ13: new selection takes effect only after a STOP.
// RQ14: read byte bits 7:4 show channel 3..0 interrupts, 1 means pending.
// RQ15: several written bytes in one transfer keep only the last.
module ichmux_top (
  input  wire       i_clk,
  input  wire       i_reset_n,
  input  wire       i_up_scl_in,
  output reg        o_up_scl_out,
  output reg        o_up_scl_oe,
  input  wire       i_up_sda_in,
  output reg        o_up_sda_out,
  output reg        o_up_sda_oe,
  input  wire [3:0] i_downstream_clock_line_in,
  output reg  [3:0] o_downstream_clock_line_out,
  output reg  [3:0] o_downstream_clock_line_oe,
  input  wire [3:0] i_downstream_data_line_in,
  output reg  [3:0] o_downstream_data_line_out,
  output reg  [3:0] o_downstream_data_line_oe,
  input  wire       i_chan0_irq_in_n,
  input  wire       i_chan1_irq_in_n,
  input  wire       i_chan2_irq_in_n,
  input  wire       i_chan3_irq_in_n,
  input  wire       i_slave_addr_strap_0,
  input  wire       i_slave_addr_strap_1,
  input  wire       i_slave_addr_strap_2,
  output reg        o_irq_n
);

  reg  [`ICHMUX_SY_W-1:0] sy1_q;
  reg  [`ICHMUX_SY_W-1:0] sy2_q;
  reg                     scl_p_q;
  reg                     sda_p_q;
  reg  [2:0]              st_q;
  reg  [3:0]              cnt_q;
  reg  [7:0]              rx_q;
  reg  [7:0]              tx_q;
  reg                     drv_q;
  reg  [2:0]              ctl_q;
  reg  [2:0]              pend_q;
  reg                     pend_vld_q;
  reg  [`ICHMUX_OE_W-1:0] oe_q;
  reg  [`ICHMUX_OE_W-1:0] h1_q;
  reg  [`ICHMUX_OE_W-1:0] h2_q;
  reg  [`ICHMUX_OE_W-1:0] h3_q;

  wire [`ICHMUX_SY_W-1:0] pins;
  wire                    scl;
  wire                    sda;
  wire [3:0]              dclk;
  wire [3:0]              ddat;
  wire [3:0]              irq_n;
  wire [2:0]              strap;
  wire                    scl_rise;
  wire                    scl_fall;
  wire                    start_ev;
  wire                    stop_ev;
  wire [6:0]              my_addr;
  wire [7:0]              rd_byte;
  wire [3:0]              sel;
  wire [`ICHMUX_OE_W-1:0] busy;
  wire [`ICHMUX_OE_W-1:0] oe_d;
  wire [3:0]              up_clk_req;
  wire [3:0]              up_dat_req;

  assign pins = {i_slave_addr_strap_2, i_slave_addr_strap_1, i_slave_addr_strap_0,
                 i_chan3_irq_in_n, i_chan2_irq_in_n, i_chan1_irq_in_n, i_chan0_irq_in_n,
                 i_downstream_data_line_in, i_downstream_clock_line_in,
                 i_up_sda_in, i_up_scl_in};

  assign scl   = sy2_q[`ICHMUX_SY_SCL];
  assign sda   = sy2_q[`ICHMUX_SY_SDA];
  assign dclk  = sy2_q[`ICHMUX_SY_DCLK_LO +: 4];
  assign ddat  = sy2_q[`ICHMUX_SY_DDAT_LO +: 4];
  assign irq_n = sy2_q[`ICHMUX_SY_IRQ_LO +: 4]; // RQ4
  assign strap = sy2_q[`ICHMUX_SY_STRAP_LO +: 3];

  assign scl_rise = scl & ~scl_p_q; // RQ10
  assign scl_fall = ~scl & scl_p_q;
  assign start_ev = scl & scl_p_q & sda_p_q & ~sda;
  assign stop_ev  = scl & scl_p_q & ~sda_p_q & sda;
  assign my_addr  = {`ICHMUX_ADDR_HI, strap}; // RQ8
  assign rd_byte  = {~irq_n, 1'b0, ctl_q}; // RQ14

  // line still owned by us, or released too recently for the sampled
  // level to show it; blocks the opposite direction to avoid latch-up
  assign busy = oe_q | h1_q | h2_q | h3_q;

  genvar ch;
  generate
    for (ch = 0; ch < 4; ch = ch + 1) begin : g_chan
      localparam [1:0] chan_idx = ch;
      assign sel[ch] = ctl_q[`ICHMUX_CTL_EN] &
                       (ctl_q[`ICHMUX_CTL_SEL_HI:0] == chan_idx); // RQ12
      assign oe_d[ch]     = sel[ch] & ~scl & ~busy[`ICHMUX_OE_UCLK]; // RQ1
      // own ack or read bit on the upstream data is not passed down
      assign oe_d[ch + 4] = sel[ch] & ~sda & ~busy[`ICHMUX_OE_UDAT] & ~drv_q; // RQ1
      assign up_clk_req[ch] = sel[ch] & ~dclk[ch] & ~busy[ch];
      assign up_dat_req[ch] = sel[ch] & ~ddat[ch] & ~busy[ch + 4];
    end
  endgenerate

  assign oe_d[`ICHMUX_OE_UCLK] = |up_clk_req; // RQ2
  assign oe_d[`ICHMUX_OE_UDAT] = drv_q | (|up_dat_req);

  // input sampling, two flops on every pin
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sy1_q   <= {`ICHMUX_SY_W{1'b1}};
      sy2_q   <= {`ICHMUX_SY_W{1'b1}};
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      sy1_q   <= pins;
      sy2_q   <= sy1_q;
      scl_p_q <= scl;
      sda_p_q <= sda;
    end
  end

  // slave state machine
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_q       <= `ICHMUX_ST_IDLE; // RQ7
      cnt_q      <= 4'h0;
      rx_q       <= 8'h00;
      tx_q       <= 8'h00;
      drv_q      <= 1'b0;
      ctl_q      <= `ICHMUX_CTL_RST; // RQ7
      pend_q     <= `ICHMUX_CTL_RST;
      pend_vld_q <= 1'b0;
    end else if (stop_ev) begin
      st_q  <= `ICHMUX_ST_IDLE;
      drv_q <= 1'b0;
      if (pend_vld_q) begin
        ctl_q <= pend_q; // RQ13 RQ11
      end
      pend_vld_q <= 1'b0;
    end else if (start_ev) begin
      st_q  <= `ICHMUX_ST_ADDR; // RQ9
      cnt_q <= 4'h0;
      drv_q <= 1'b0;
    end else if (scl_rise) begin
      case (st_q)
        `ICHMUX_ST_ADDR, `ICHMUX_ST_WR: begin
          rx_q  <= {rx_q[6:0], sda};
          cnt_q <= cnt_q + 4'h1;
        end
        `ICHMUX_ST_RACK: begin
          st_q <= sda ? `ICHMUX_ST_IDLE : `ICHMUX_ST_RACK2;
        end
        default: begin
          st_q <= st_q;
        end
      endcase
    end else if (scl_fall) begin
      case (st_q)
        `ICHMUX_ST_ADDR: begin
          if (cnt_q == `ICHMUX_BYTE_BITS) begin
            if (rx_q[7:1] == my_addr) begin // RQ8
              st_q  <= `ICHMUX_ST_ACKA;
              drv_q <= 1'b1;
            end else begin
              st_q <= `ICHMUX_ST_IDLE;
            end
          end
        end
        `ICHMUX_ST_ACKA: begin
          cnt_q <= 4'h0;
          if (rx_q[0]) begin
            st_q  <= `ICHMUX_ST_RD;
            tx_q  <= {rd_byte[6:0], 1'b0};
            drv_q <= ~rd_byte[7];
            cnt_q <= 4'h1;
          end else begin
            st_q  <= `ICHMUX_ST_WR;
            drv_q <= 1'b0;
          end
        end
        `ICHMUX_ST_WR: begin
          if (cnt_q == `ICHMUX_BYTE_BITS) begin
            pend_q     <= rx_q[2:0]; // RQ15
            pend_vld_q <= 1'b1; // RQ3
            st_q       <= `ICHMUX_ST_ACKW;
            drv_q      <= 1'b1;
          end
        end
        `ICHMUX_ST_ACKW: begin
          st_q  <= `ICHMUX_ST_WR;
          cnt_q <= 4'h0;
          drv_q <= 1'b0;
        end
        `ICHMUX_ST_RD: begin
          if (cnt_q == `ICHMUX_BYTE_BITS) begin
            st_q  <= `ICHMUX_ST_RACK;
            drv_q <= 1'b0;
          end else begin
            drv_q <= ~tx_q[7];
            tx_q  <= {tx_q[6:0], 1'b0};
            cnt_q <= cnt_q + 4'h1;
          end
        end
        `ICHMUX_ST_RACK2: begin
          st_q  <= `ICHMUX_ST_RD;
          tx_q  <= {rd_byte[6:0], 1'b0};
          drv_q <= ~rd_byte[7];
          cnt_q <= 4'h1;
        end
        default: begin
          st_q <= st_q;
        end
      endcase
    end
  end

  // pass-through drives and pin outputs
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      oe_q                        <= {`ICHMUX_OE_W{1'b0}}; // RQ7
      h1_q                        <= {`ICHMUX_OE_W{1'b0}};
      h2_q                        <= {`ICHMUX_OE_W{1'b0}};
      h3_q                        <= {`ICHMUX_OE_W{1'b0}};
      o_up_scl_out                <= 1'b0;
      o_up_scl_oe                 <= 1'b0;
      o_up_sda_out                <= 1'b0;
      o_up_sda_oe                 <= 1'b0;
      o_downstream_clock_line_out <= 4'h0;
      o_downstream_clock_line_oe  <= 4'h0;
      o_downstream_data_line_out  <= 4'h0;
      o_downstream_data_line_oe   <= 4'h0;
      o_irq_n                     <= 1'b1;
    end else begin
      oe_q                        <= oe_d;
      h1_q                        <= oe_q;
      h2_q                        <= h1_q;
      h3_q                        <= h2_q;
      o_up_scl_oe                 <= oe_d[`ICHMUX_OE_UCLK];
      o_up_sda_oe                 <= oe_d[`ICHMUX_OE_UDAT];
      o_downstream_clock_line_oe  <= oe_d[3:0]; // RQ2
      o_downstream_data_line_oe   <= oe_d[7:4]; // RQ2
      o_irq_n                     <= &irq_n; // RQ5 RQ6
    end
  end

endmodule // ichmux_top
`default_nettype wire

// ==== testbench/ichmux_asserts.sv ====
/* checker on the mux top ports; bound into every instance of the top */
`default_nettype none
module ichmux_asserts (
  input wire logic       i_clk,
  input wire logic       i_reset_n,
  input wire logic       i_up_scl_in,
  input wire logic       o_up_scl_oe,
  input wire logic       o_up_sda_oe,
  input wire logic [3:0] i_downstream_clock_line_in,
  input wire logic [3:0] o_downstream_clock_line_oe,
  input wire logic [3:0] o_downstream_data_line_oe,
  input wire logic       i_chan0_irq_in_n,
  input wire logic       i_chan1_irq_in_n,
  input wire logic       i_chan2_irq_in_n,
  input wire logic       i_chan3_irq_in_n,
  input wire logic       o_irq_n
);
  timeunit 1ns;
  timeprecision 1ns;
  wire logic [3:0] irq_w = {i_chan3_irq_in_n, i_chan2_irq_in_n,
                            i_chan1_irq_in_n, i_chan0_irq_in_n};
  wire logic [3:0] any_oe = o_downstream_clock_line_oe | o_downstream_data_line_oe;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  chk_irq_and: assert property (o_irq_n == $past(&irq_w, 3))
    else $error("irq output is not the and of inputs");
  chk_irq_low: assert property ($fell(o_irq_n) |-> $past(irq_w, 3) != 4'hF)
    else $error("irq output fell with no input low");
  chk_one_chan: assert property ($onehot0(any_oe))
    else $error("more than one channel driven");
  chk_up_cause: assert property ($rose(o_up_scl_oe) |->
                                 $past(i_downstream_clock_line_in, 3) != 4'hF)
    else $error("upstream clock pulled with no channel low");
  chk_dn_cause: assert property ($rose(|o_downstream_clock_line_oe) |-> !$past(i_up_scl_in, 3))
    else $error("channel clock pulled with upstream high");
  chk_clk_loop: assert property (!(o_up_scl_oe && (|o_downstream_clock_line_oe)))
    else $error("clock driven both ways");
  chk_dat_loop: assert property (!(o_up_sda_oe && (|o_downstream_data_line_oe)))
    else $error("data driven both ways");
  chk_reset_idle: assert property ($rose(i_reset_n) |->
                                   !o_up_scl_oe && o_downstream_clock_line_oe == 4'h0)
    else $error("lines driven out of reset");
  cover property (!o_irq_n);
  cover property (o_up_scl_oe);
  cover property (|o_downstream_clock_line_oe);
endmodule // ichmux_asserts
bind ichmux_top ichmux_asserts u_ichmux_asserts (.*);
`default_nettype wire

// ==== testbench/ichmux_master.sv ====
/* upstream two-wire master model; wires resolved open-drain by the bench */
`default_nettype none
module ichmux_master (
  input  wire logic i_scl,
  input  wire logic i_sda,
  output var logic  o_scl_oe,
  output var logic  o_sda_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {o_scl_oe, o_sda_oe} = 2'h0;
  // one bit of 160 ns, clock stands still between frames
  task automatic bit_io(input logic b, output logic q);
    o_sda_oe = ~b;
    #40 o_scl_oe = 1'b0;
    #40 q = i_sda;
    #40 o_scl_oe = 1'b1;
    #40;
  endtask
  task automatic start();
    o_sda_oe = 1'b1;
    #80 o_scl_oe = 1'b1;
    #40;
  endtask
  task automatic stop();
    o_sda_oe = 1'b1;
    #40 o_scl_oe = 1'b0;
    #80 o_sda_oe = 1'b0;
    #80;
  endtask
  task automatic xfer(input logic [7:0] b, input logic a, output logic [7:0] q, output logic k);
    for (int i = 7; i >= 0; i--) bit_io(b[i], q[i]);
    bit_io(a, k);
  endtask
endmodule // ichmux_master
`default_nettype wire

// ==== testbench/test_ichmux_top.sv ====
/* bench for the mux: master model on the upstream pair, model compare;
   assumes the design, master model and checker compiled before it */
`default_nettype none
`include "ichmux_regs.vh"
module test_ichmux_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic       i_clk, i_reset_n, m_scl_oe, m_sda_oe, up_pull, ak, o_irq_n;
  logic       o_up_scl_out, o_up_scl_oe, o_up_sda_out, o_up_sda_oe;
  logic [3:0] o_downstream_clock_line_out, o_downstream_clock_line_oe, dn_pull, irq_n;
  logic [3:0] o_downstream_data_line_out, o_downstream_data_line_oe;
  logic [2:0] strap;
  logic [7:0] mdl_ctl, d, r;
  int         seed, err_total, checks_done;
  wire logic  i_up_scl_in = ~(m_scl_oe | o_up_scl_oe | up_pull);
  wire logic  i_up_sda_in = ~(m_sda_oe | o_up_sda_oe);
  wire logic [3:0] i_downstream_clock_line_in = ~(o_downstream_clock_line_oe | dn_pull);
  wire logic [3:0] i_downstream_data_line_in = ~o_downstream_data_line_oe;
  wire logic  i_chan0_irq_in_n = irq_n[0], i_chan1_irq_in_n = irq_n[1];
  wire logic  i_chan2_irq_in_n = irq_n[2], i_chan3_irq_in_n = irq_n[3];
  wire logic  i_slave_addr_strap_0 = strap[0], i_slave_addr_strap_1 = strap[1];
  wire logic  i_slave_addr_strap_2 = strap[2];
  ichmux_top u_ichmux_top (.*);
  ichmux_master u_ichmux_master (.i_scl(i_up_scl_in), .i_sda(i_up_sda_in),
                                 .o_scl_oe(m_scl_oe), .o_sda_oe(m_sda_oe));
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [3:0] exp_dn();
    return mdl_ctl[2] ? 4'h1 << mdl_ctl[1:0] : 4'h0;
  endfunction
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic access(input logic [6:0] ad, input logic rd, input logic two);
    logic x;
    @(posedge i_clk);
    #2 u_ichmux_master.start();
    u_ichmux_master.xfer({ad, rd}, 1'b1, r, ak);
    if (!ak && two) u_ichmux_master.xfer(~d, 1'b1, r, x);
    if (!ak) u_ichmux_master.xfer(rd ? 8'hFF : d, rd, r, x);
    #100 chk(o_downstream_clock_line_oe, exp_dn());
    u_ichmux_master.stop();
  endtask
  // pull each side in turn, expect passing on the selected pair only
  task automatic pass_chk();
    @(posedge i_clk);
    #2 up_pull = 1'b1;
    repeat (8) @(posedge i_clk);
    #1 chk(o_downstream_clock_line_oe, exp_dn());
    chk({o_downstream_clock_line_out, o_downstream_data_line_out}, 8'h00);
    chk({o_up_scl_out, o_up_sda_out}, 8'h00);
    #2 up_pull = 1'b0;
    repeat (8) @(posedge i_clk);
    #2 dn_pull = 4'hF;
    repeat (8) @(posedge i_clk);
    #1 chk(o_up_scl_oe, mdl_ctl[2]);
    #2 dn_pull = 4'h0;
    repeat (8) @(posedge i_clk);
  endtask
  initial begin
    {i_reset_n, up_pull, dn_pull, err_total, checks_done} = '0;
    irq_n = 4'hF;
    seed = 60310;
    strap = 3'($random(seed));
    mdl_ctl = 8'h00;
    repeat (16) @(posedge i_clk);
    #2 i_reset_n = 1'b1;
    repeat (4) @(posedge i_clk);
    pass_chk();
    for (int i = 0; i < 12; i++) begin
      d = $random(seed);
      if (i < 8) d[2:0] = i[2:0];
      @(posedge i_clk);
      #2 irq_n = 4'($random(seed));
      access({`ICHMUX_ADDR_HI, i == 10 ? ~strap : strap}, 1'b0, i[0]);
      chk(ak, i == 10);
      if (i != 10) mdl_ctl = d;
      pass_chk();
      access({`ICHMUX_ADDR_HI, strap}, 1'b1, 1'b0);
      chk(r, {~irq_n, 1'b0, mdl_ctl[2:0]});
      chk(o_irq_n, &irq_n);
    end
    give_verdict();
  end
  initial begin
    #1ms;
    err_total++;
    give_verdict();
  end
endmodule // test_ichmux_top
`default_nettype wire
